// >>> rtl/fpm_pkg.sv
// Purpose: shared constants and types for the front panel menu controller
// Assumes: 100 MHz clock
// Notes:   gain held as signed dBu, item list kept short on purpose
package fpm_pkg;
    localparam int           CLK_HZ          = 100_000_000;
    localparam int           DEBOUNCE_MS     = 10;
    localparam int           DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int           RPT_DELAY_MS    = 500;
    localparam int           RPT_DELAY_CYC   = CLK_HZ / 1000 * RPT_DELAY_MS;
    localparam int           RPT_RATE_MS     = 100;
    localparam int           RPT_RATE_CYC    = CLK_HZ / 1000 * RPT_RATE_MS;
    localparam int           TICK_US         = 1; // ticks run in us here; 1000 gives ms
    localparam int           TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
    localparam int           TICK_W          = 17;
    localparam int           MS_W            = 10;
    localparam logic [MS_W-1:0] DEBOUNCE_TICKS = MS_W'(DEBOUNCE_MS);
    localparam logic [MS_W-1:0] RPT_DELAY_TICKS = MS_W'(RPT_DELAY_MS);
    localparam logic [MS_W-1:0] RPT_RATE_TICKS  = MS_W'(RPT_RATE_MS);

    localparam int           NUM_SW          = 7;
    localparam int           SW_SET          = 0;
    localparam int           SW_DOWN         = 1;
    localparam int           SW_UP           = 2;
    localparam int           SW_RUN          = 3;
    localparam int           SW_RATE         = 4;
    localparam int           SW_CLKREF       = 5;
    localparam int           SW_POSREF       = 6;

    localparam int           ITEM_W          = 3;
    localparam logic [ITEM_W-1:0] ITEM_GEN_SETUP   = 3'h0;
    localparam logic [ITEM_W-1:0] ITEM_TC_GAIN     = 3'h1;
    localparam logic [ITEM_W-1:0] ITEM_SAMPLE_RATE = 3'h2;
    localparam logic [ITEM_W-1:0] ITEM_VIDEO_SYNC  = 3'h3;
    localparam logic [ITEM_W-1:0] ITEM_LAST        = 3'h3;

    localparam int           VAL_W           = 8;
    localparam logic signed [VAL_W-1:0] GAIN_STEP  = 8'sh03;
    localparam logic signed [VAL_W-1:0] GAIN_MIN   = -8'sh18;
    localparam logic signed [VAL_W-1:0] GAIN_MAX   = 8'sh09;
    localparam logic signed [VAL_W-1:0] GAIN_RESET = 8'sh00;
    localparam logic [VAL_W-1:0] GEN_MODE_LAST  = 8'h01;
    localparam logic [VAL_W-1:0] SRATE_LAST     = 8'h03;
    localparam logic [VAL_W-1:0] VSYNC_LAST     = 8'h01;

    localparam int           RATE_W          = 3;
    localparam logic [RATE_W-1:0] RATE_LAST     = 3'h5;
    localparam logic [RATE_W-1:0] RATE_DF_A     = 3'h2;
    localparam logic [RATE_W-1:0] RATE_DF_B     = 3'h4;
    localparam int           CREF_W          = 3;
    localparam logic [CREF_W-1:0] CREF_LAST     = 3'h4;

    localparam int           FIELD_W         = 2;
    localparam logic [FIELD_W-1:0] FIELD_HOURS  = 2'h0;

    typedef enum logic [1:0] {DISP_TC, DISP_NAME, DISP_VALUE} fpm_disp_type;
endpackage : fpm_pkg

// >>> rtl/fpm_sw_if.sv
// Purpose: carries debounced switch events from the switch conditioner
// Assumes: one clock domain
// Notes:   press and repeat are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface fpm_sw_if;
    import fpm_pkg::*;
    logic [NUM_SW-1:0] level;
    logic [NUM_SW-1:0] press;
    logic [NUM_SW-1:0] repeatStep;
    modport src (output level, press, repeatStep);
    modport dst (input  level, press, repeatStep);
endinterface : fpm_sw_if
`default_nettype wire

// >>> rtl/fpm_switch.sv
// Purpose: synchronise, debounce and edge-detect one front panel switch
// Assumes: tick is a one-cycle enable from the shared divider
// Notes:   repeat only fires while held past the first delay
`timescale 1ns/1ps
`default_nettype none
module fpm_switch
    import fpm_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tick,
    input  wire logic rawPin,
    input  wire logic repeatEn,
    output logic      level,
    output logic      press,
    output logic      repeatStep
);
    logic [2:0]      sync;
    logic [MS_W-1:0] stableCnt;
    logic [MS_W-1:0] holdCnt;
    logic            held;

    always_ff @(posedge clk) begin
        if (rst) sync <= 3'h0;
        else     sync <= {sync[1:0], rawPin};
    end

    // a change counts only once the two later stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            held      <= 1'b0;
            stableCnt <= '0;
        end else if (sync[2] != sync[1] || sync[1] == held) begin
            stableCnt <= '0;
        end else if (tick) begin
            if (stableCnt == DEBOUNCE_TICKS - MS_W'(1)) begin
                held      <= sync[1];
                stableCnt <= '0;
            end else begin
                stableCnt <= stableCnt + MS_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 1'b0;
            press <= 1'b0;
        end else begin
            level <= held;
            press <= held & ~level;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !held || !repeatEn) begin
            holdCnt    <= '0;
            repeatStep <= 1'b0;
        end else begin
            repeatStep <= 1'b0;
            if (tick) begin
                if (holdCnt == RPT_DELAY_TICKS) begin
                    holdCnt    <= RPT_DELAY_TICKS - RPT_RATE_TICKS;
                    repeatStep <= 1'b1;
                end else begin
                    holdCnt <= holdCnt + MS_W'(1);
                end
            end
        end
    end
endmodule : fpm_switch
`default_nettype wire

// >>> rtl/fpm_front_panel.sv
// Purpose: front panel menu controller of the synchronisation unit
// Assumes: raw switches active high, host writes are one-cycle strobes
// Notes:   values are committed only on the final set press
// Summary of operation
// - clock, position, rate chord exits lockout
// - set in time code shows names
// - set on name shows its value
// - set on value commits, back to time code
// - up/down step through parameter names
// - up/down step values, not committed
// - up+down together tabs time code field
// - run/stop toggles generator in preset mode
// - clear resets counter in time code view
// - elsewhere run/stop/clear cancels the edit
// - holding up/down auto-repeats the step
// - name view starts on last or setup item
// - gain steps by 3 dBu
// - rate switch cycles rates, lights drop frame
// - clock reference switch cycles sources
// - omitted items have no menu entry
// - host frame rate write is adopted
// - lockout ignores switches except the chord, lights indicator
// - gain limited to -24..+9 dBu
`timescale 1ns/1ps
`default_nettype none
module fpm_front_panel
    import fpm_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [fpm_pkg::NUM_SW-1:0] rawSwitch,
    input  wire logic                       lockoutSet,
    input  wire logic                       lockoutClear,
    input  wire logic                       hostRateWrite,
    input  wire logic [fpm_pkg::RATE_W-1:0] hostRate,
    input  wire logic                       presetMode,
    output fpm_pkg::fpm_disp_type           dispState,
    output logic [fpm_pkg::ITEM_W-1:0]      itemSel,
    output logic [fpm_pkg::VAL_W-1:0]       editValue,
    output logic [fpm_pkg::FIELD_W-1:0]     editField,
    output logic                            tcEditing,
    output logic                            remoteOnly,
    output logic                            genRunning,
    output logic                            counterClear,
    output logic [fpm_pkg::RATE_W-1:0]      frameRate,
    output logic                            drop_frame_indicator,
    output logic [fpm_pkg::CREF_W-1:0]      clockRef,
    output logic                            posRefStep,
    output logic [fpm_pkg::VAL_W-1:0]       genSetupMode,
    output logic signed [fpm_pkg::VAL_W-1:0] tcGain,
    output logic [fpm_pkg::VAL_W-1:0]       sampleRate,
    output logic [fpm_pkg::VAL_W-1:0]       videoSync
);
    import fpm_pkg::*;

    fpm_sw_if sw ();

    logic [TICK_W-1:0] tickCnt;
    logic              tick;
    logic              scrollRepeat;

    always_ff @(posedge clk) begin
        if (rst || tick) tickCnt <= '0;
        else             tickCnt <= tickCnt + TICK_W'(1);
    end
    assign tick = (tickCnt == TICK_W'(TICK_CYC - 1));

    // repeat disabled while both held so a tab never scrolls too
    assign scrollRepeat = !(sw.level[SW_UP] && sw.level[SW_DOWN]);

    genvar g;
    generate
        for (g = 0; g < NUM_SW; g++) begin : gSw
            fpm_switch uSw (
                .clk        (clk),
                .rst        (rst),
                .tick       (tick),
                .rawPin     (rawSwitch[g]),
                .repeatEn   ((g == SW_UP || g == SW_DOWN) && scrollRepeat),
                .level      (sw.level[g]),
                .press      (sw.press[g]),
                .repeatStep (sw.repeatStep[g])
            );
        end
    endgenerate

    logic chord;
    logic active;
    logic setEv;
    logic upEv;
    logic downEv;
    logic tabEv;
    logic runEv;

    assign chord  = sw.level[SW_CLKREF] && sw.level[SW_POSREF] && sw.level[SW_RATE];
    assign active = !remoteOnly;
    assign tabEv  = active && tcEditing && sw.level[SW_UP] && sw.level[SW_DOWN]
                    && (sw.press[SW_UP] || sw.press[SW_DOWN]);
    assign setEv  = active && sw.press[SW_SET];
    assign upEv   = active && !tabEv && (sw.press[SW_UP] || sw.repeatStep[SW_UP]);
    assign downEv = active && !tabEv && (sw.press[SW_DOWN] || sw.repeatStep[SW_DOWN]);
    assign runEv  = active && sw.press[SW_RUN];

    // lockout: set wins over the chord
    always_ff @(posedge clk) begin
        if (rst)                      remoteOnly <= 1'b0;
        else if (lockoutSet)          remoteOnly <= 1'b1;
        else if (chord || lockoutClear) remoteOnly <= 1'b0;
    end

    function automatic logic [VAL_W-1:0] stepVal(
        input logic [ITEM_W-1:0] item,
        input logic [VAL_W-1:0]  v,
        input logic              up
    );
        logic [VAL_W-1:0]        last;
        logic signed [VAL_W-1:0] s;
        last = '0;
        s    = signed'(v);
        if (item == ITEM_TC_GAIN) begin
            if (up) s = (s > GAIN_MAX - GAIN_STEP) ? GAIN_MAX : s + GAIN_STEP;
            else    s = (s < GAIN_MIN + GAIN_STEP) ? GAIN_MIN : s - GAIN_STEP;
            return unsigned'(s);
        end
        unique case (item)
            ITEM_GEN_SETUP:   last = GEN_MODE_LAST;
            ITEM_SAMPLE_RATE: last = SRATE_LAST;
            default:          last = VSYNC_LAST;
        endcase
        if (up) return (v >= last) ? '0 : v + VAL_W'(1);
        return (v == '0) ? last : v - VAL_W'(1);
    endfunction : stepVal

    logic [VAL_W-1:0] storedVal;
    always_comb begin
        unique case (itemSel)
            ITEM_GEN_SETUP:   storedVal = genSetupMode;
            ITEM_TC_GAIN:     storedVal = unsigned'(tcGain);
            ITEM_SAMPLE_RATE: storedVal = sampleRate;
            default:          storedVal = videoSync;
        endcase
    end

    logic commit;
    assign commit = setEv && dispState == DISP_VALUE;

    // display machine
    always_ff @(posedge clk) begin
        if (rst) begin
            dispState <= DISP_TC;
        end else begin
            unique case (dispState)
                DISP_TC:    if (setEv) dispState <= DISP_NAME;
                DISP_NAME:  if (setEv) dispState <= DISP_VALUE;
                            else if (runEv) dispState <= DISP_TC;
                DISP_VALUE: if (setEv || runEv) dispState <= DISP_TC;
                default:    dispState <= DISP_TC;
            endcase
        end
    end

    // item stays as last chosen so the name view reopens on it
    always_ff @(posedge clk) begin
        if (rst) begin
            itemSel <= ITEM_GEN_SETUP;
        end else if (dispState == DISP_NAME) begin
            // omitted items simply have no code in this list
            if (upEv)        itemSel <= (itemSel == ITEM_LAST) ? '0 : itemSel + ITEM_W'(1);
            else if (downEv) itemSel <= (itemSel == '0) ? ITEM_LAST : itemSel - ITEM_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            editValue <= '0;
        end else if (dispState == DISP_NAME) begin
            editValue <= storedVal;
        end else if (dispState == DISP_VALUE) begin
            if (upEv)        editValue <= stepVal(itemSel, editValue, 1'b1);
            else if (downEv) editValue <= stepVal(itemSel, editValue, 1'b0);
        end
    end

    // store changes only on commit, so cancel keeps the old value
    always_ff @(posedge clk) begin
        if (rst) begin
            genSetupMode <= '0;
            tcGain       <= GAIN_RESET;
            sampleRate   <= '0;
            videoSync    <= '0;
        end else if (commit) begin
            unique case (itemSel)
                ITEM_GEN_SETUP:   genSetupMode <= editValue;
                ITEM_TC_GAIN:     tcGain       <= signed'(editValue);
                ITEM_SAMPLE_RATE: sampleRate   <= editValue;
                default:          videoSync    <= editValue;
            endcase
        end
    end

    // time code field entry is open in the time code view in preset mode while the generator is stopped
    always_ff @(posedge clk) begin
        if (rst) tcEditing <= 1'b0;
        else     tcEditing <= presetMode && !genRunning && dispState == DISP_TC;
    end

    always_ff @(posedge clk) begin
        if (rst || !tcEditing) editField <= FIELD_HOURS;
        else if (tabEv)        editField <= editField + FIELD_W'(1);
    end

    always_ff @(posedge clk) begin
        if (rst)                                     genRunning <= 1'b0;
        else if (!presetMode)                        genRunning <= 1'b0;
        else if (runEv && dispState == DISP_TC)      genRunning <= !genRunning;
    end

    always_ff @(posedge clk) begin
        if (rst) counterClear <= 1'b0;
        else     counterClear <= runEv && dispState == DISP_TC && !presetMode;
    end

    // host write wins over a front panel press in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            frameRate <= '0;
        end else if (hostRateWrite) begin
            frameRate <= (hostRate > RATE_LAST) ? RATE_LAST : hostRate;
        end else if (active && sw.press[SW_RATE]) begin
            frameRate <= (frameRate == RATE_LAST) ? '0 : frameRate + RATE_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) drop_frame_indicator <= 1'b0;
        else     drop_frame_indicator <= frameRate == RATE_DF_A || frameRate == RATE_DF_B;
    end

    always_ff @(posedge clk) begin
        if (rst)                                clockRef <= '0;
        else if (active && sw.press[SW_CLKREF]) clockRef <= (clockRef == CREF_LAST) ? '0
                                                            : clockRef + CREF_W'(1);
    end

    always_ff @(posedge clk) begin
        if (rst) posRefStep <= 1'b0;
        else     posRefStep <= active && sw.press[SW_POSREF];
    end
endmodule : fpm_front_panel
`default_nettype wire

// >>> test/fpm_front_panel_properties.sv
// Purpose: port-level properties of the front panel menu controller
// Assumes: one clock domain, synchronous active high reset
// Notes:   long debounce counts are left to the bench; repeat counts are not checked
`timescale 1ns/1ps
`default_nettype none
module fpm_front_panel_properties
    import fpm_pkg::*;
(
    input wire logic                                clk,
    input wire logic                                rst,
    input wire logic                                lockoutSet,
    input wire logic                                hostRateWrite,
    input wire logic [fpm_pkg::RATE_W-1:0]          hostRate,
    input wire logic                                presetMode,
    input wire fpm_pkg::fpm_disp_type               dispState,
    input wire logic [fpm_pkg::ITEM_W-1:0]          itemSel,
    input wire logic [fpm_pkg::FIELD_W-1:0]         editField,
    input wire logic                                tcEditing,
    input wire logic                                remoteOnly,
    input wire logic                                genRunning,
    input wire logic                                counterClear,
    input wire logic [fpm_pkg::RATE_W-1:0]          frameRate,
    input wire logic                                drop_frame_indicator,
    input wire logic [fpm_pkg::CREF_W-1:0]          clockRef,
    input wire logic                                posRefStep,
    input wire logic signed [fpm_pkg::VAL_W-1:0]    tcGain
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    clear_pulse_a: assert property (counterClear |=> !counterClear)
        else $error("counter clear pulse longer than one cycle");
    posref_pulse_a: assert property (posRefStep |=> !posRefStep)
        else $error("positional step pulse longer than one cycle");
    drop_led_a: assert property (drop_frame_indicator ==
        $past(frameRate == RATE_DF_A || frameRate == RATE_DF_B))
        else $error("drop frame indicator disagrees with frame rate");
    gain_range_a: assert property (tcGain >= GAIN_MIN && tcGain <= GAIN_MAX)
        else $error("stored gain outside its range");
    host_rate_a: assert property (hostRateWrite |=> frameRate ==
        ($past(hostRate) > RATE_LAST ? RATE_LAST : $past(hostRate)))
        else $error("host frame rate not adopted");
    lockout_in_a: assert property (lockoutSet |=> remoteOnly)
        else $error("lockout request did not light remote only");
    lockout_freeze_a: assert property (remoteOnly && $past(remoteOnly) |->
        $stable(dispState) && $stable(itemSel))
        else $error("display moved during lockout");
    commit_only_a: assert property ($changed(tcGain) |->
        $past(dispState) == DISP_VALUE && dispState == DISP_TC)
        else $error("gain changed outside a commit");
    tab_step_a: assert property ($changed(editField) && editField != FIELD_HOURS |->
        $past(tcEditing) && editField == $past(editField) + 2'h1)
        else $error("edit field stepped wrongly");
    gen_start_a: assert property ($rose(genRunning) |-> $past(presetMode))
        else $error("generator started outside preset mode");
    item_range_a: assert property (itemSel <= ITEM_LAST && clockRef <= CREF_LAST)
        else $error("item or clock reference out of range");

    cover property ($rose(remoteOnly));
    cover property ($changed(tcGain));
    cover property (counterClear);
endmodule : fpm_front_panel_properties

bind fpm_front_panel fpm_front_panel_properties i_props (.clk, .rst, .lockoutSet,
    .hostRateWrite, .hostRate, .presetMode, .dispState, .itemSel, .editField, .tcEditing,
    .remoteOnly, .genRunning, .counterClear, .frameRate, .drop_frame_indicator, .clockRef,
    .posRefStep, .tcGain);
`default_nettype wire

// >>> test/fpm_operator.sv
// Purpose: operator at the front panel, pressing switches with chatter
// Assumes: raw switches active high, released contacts read low
// Notes:   holds long enough for debounce, far below the repeat delay
`timescale 1ns/1ps
`default_nettype none
module fpm_operator
    import fpm_pkg::*;
(
    input  wire logic                  clk,
    output logic [fpm_pkg::NUM_SW-1:0] rawSwitch
);
    localparam int HOLD_CYC = 11 * TICK_CYC;

    initial rawSwitch = '0;

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // several switches in one mask are pressed together
    task automatic push(input logic [NUM_SW-1:0] m);
        for (int i = 0; i < 3; i++) begin // contact chatter on make
            rawSwitch = m;
            wait_clk(7);
            rawSwitch = '0;
            wait_clk(5);
        end
        rawSwitch = m;
        wait_clk(HOLD_CYC);
        for (int i = 0; i < 2; i++) begin // chatter on break
            rawSwitch = '0;
            wait_clk(5);
            rawSwitch = m;
            wait_clk(5);
        end
        rawSwitch = '0;
        wait_clk(HOLD_CYC);
    endtask : push
endmodule : fpm_operator
`default_nettype wire

// >>> test/testbench.sv
// Purpose: self-checking bench for the front panel menu controller
// Assumes: outputs settle well inside one hold period of the operator
// Notes:   auto-repeat needs a long hold and is left out
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fpm_pkg::*;
    logic                     clk;
    logic                     rst;
    logic [NUM_SW-1:0]        rawSwitch;
    logic                     lockoutSet;
    logic                     lockoutClear;
    logic                     hostRateWrite;
    logic [RATE_W-1:0]        hostRate;
    logic                     presetMode;
    fpm_disp_type             dispState;
    logic [ITEM_W-1:0]        itemSel;
    logic [VAL_W-1:0]         editValue;
    logic [FIELD_W-1:0]       editField;
    logic                     tcEditing;
    logic                     remoteOnly;
    logic                     genRunning;
    logic                     counterClear;
    logic [RATE_W-1:0]        frameRate;
    logic                     drop_frame_indicator;
    logic [CREF_W-1:0]        clockRef;
    logic                     posRefStep;
    logic [VAL_W-1:0]         genSetupMode;
    logic signed [VAL_W-1:0]  tcGain;
    logic [VAL_W-1:0]         sampleRate;
    logic [VAL_W-1:0]         videoSync;
    int mismatches = 0, n_tests = 0, clrCnt = 0, posCnt = 0, expClr = 0, expPos = 0;
    int disp = 0, item = 0, val = 0, rate = 0, cref = 0, field = 0;
    int par[4] = '{0, 0, 0, 0};
    int lim[4] = '{int'(GEN_MODE_LAST), 0, int'(SRATE_LAST), int'(VSYNC_LAST)};
    int run = 0, remote = 0, n = 0;

    fpm_operator i_op (.clk, .rawSwitch);
    fpm_front_panel i_dut (.clk, .rst, .rawSwitch, .lockoutSet, .lockoutClear, .hostRateWrite,
        .hostRate, .presetMode, .dispState, .itemSel, .editValue, .editField, .tcEditing,
        .remoteOnly, .genRunning, .counterClear, .frameRate, .drop_frame_indicator, .clockRef,
        .posRefStep, .genSetupMode, .tcGain, .sampleRate, .videoSync);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (counterClear === 1'b1) clrCnt++;
        if (posRefStep === 1'b1) posCnt++;
    end

    task automatic stop_test();
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic check_all();
        chk(8'(dispState), 8'(disp));
        chk(8'(itemSel), 8'(item));
        if (disp == 2) chk(editValue, 8'(val));
        chk(tcGain, 8'(par[1]));
        chk(genSetupMode, 8'(par[0]));
        chk(sampleRate, 8'(par[2]));
        chk(videoSync, 8'(par[3]));
        chk(8'(frameRate), 8'(rate));
        chk(8'(drop_frame_indicator), 8'(rate == 2 || rate == 4));
        chk(8'(clockRef), 8'(cref));
        chk(8'(editField), 8'(field));
        chk(8'(genRunning), 8'(run));
        chk(8'(tcEditing), 8'(presetMode === 1'b1 && run == 0 && disp == 0));
        chk(8'(remoteOnly), 8'(remote));
        chk(8'(clrCnt), 8'(expClr));
        chk(8'(posCnt), 8'(expPos));
    endtask : check_all

    task automatic act(input logic [NUM_SW-1:0] m);
        int s;
        int t;
        i_op.push(m);
        s = (m == 7'h04) ? 1 : -1;
        t = 0;
        if (remote == 0) case (m)
            7'h01: begin
                if (disp == 2) par[item] = val;
                if (disp == 1) val = par[item];
                disp = (disp + 1) % 3;
            end
            7'h02, 7'h04: begin
                t = (item == 1) ? val + 3 * s : val + s;
                if (disp == 1) item = (item + s + 4) % 4;
                if (disp == 2 && item == 1) val = (t > 9) ? 9 : (t < -24) ? -24 : t;
                else if (disp == 2) val = (t > lim[item]) ? 0 : (t < 0) ? lim[item] : t;
            end
            7'h06: if (presetMode === 1'b1 && run == 0 && disp == 0) field = (field + 1) % 4;
            7'h08: begin
                if (disp != 0) disp = 0;
                else if (presetMode === 1'b1) run = 1 - run;
                else expClr++;
            end
            7'h10: rate = (rate + 1) % 6;
            7'h20: cref = (cref + 1) % 5;
            7'h40: expPos++;
            default: ;
        endcase
        check_all();
    endtask : act

    initial begin
        rst = 1'b1;
        lockoutSet = 1'b0;
        lockoutClear = 1'b0;
        hostRateWrite = 1'b0;
        hostRate = '0;
        presetMode = 1'b0;
        void'($urandom(32'h448c));
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        check_all();
        act(7'h01);
        act(7'h04);
        act(7'h01);
        repeat (4) act(7'h04);
        act(7'h08);
        act(7'h01);
        act(7'h01);
        act(7'h02);
        act(7'h01);
        act(7'h08);
        act(7'h01);
        repeat (2) act(7'h02);
        act(7'h08);
        repeat (2) act(7'h01);
        act(7'h02);
        act(7'h01);
        presetMode = 1'b1;
        repeat (2) act(7'h08);
        act(7'h06);
        n = $urandom_range(7, 1);
        repeat (n) act(7'h10);
        hostRate = 3'($urandom_range(7, 0));
        hostRateWrite = 1'b1;
        @(posedge clk);
        #1 hostRateWrite = 1'b0;
        rate = (hostRate > 5) ? 5 : int'(hostRate);
        repeat (3) @(posedge clk);
        check_all();
        n = $urandom_range(6, 1);
        repeat (n) act(7'h20);
        act(7'h40);
        lockoutSet = 1'b1;
        @(posedge clk);
        #1 lockoutSet = 1'b0;
        remote = 1;
        act(7'h01);
        i_op.push(7'h70);
        chk(8'(remoteOnly), 8'h00);
        remote = 0;
        check_all();
        lockoutSet = 1'b1;
        @(posedge clk);
        #1 lockoutSet = 1'b0;
        lockoutClear = 1'b1;
        chk(8'(remoteOnly), 8'h01);
        @(posedge clk);
        #1 lockoutClear = 1'b0;
        chk(8'(remoteOnly), 8'h00);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
